// ### verilog/fsh_host_port.sv
`timescale 1ns/1ps
module fsh_host_port
#(
	parameter int TA_PRESCALE = fsh_pkg::TA_PRESCALE,
	parameter int TB_PRESCALE = fsh_pkg::TB_PRESCALE
)
(
	input  wire logic                            sys_clk,
	input  wire logic                            sys_rst,
	input  wire logic                            initial_clear_n,
	input  wire logic                            chipSelectN,
	input  wire logic                            writeN,
	input  wire logic                            readN,
	input  wire logic                            addr_data_select,
	input  wire logic [fsh_pkg::BUS_W-1:0]       busIn,
	output      logic [fsh_pkg::BUS_W-1:0]       busOut,
	output      logic                            busOe,
	output      logic                            irqOut,
	output      logic                            irqOe,
	output      logic                            control_out_one,
	output      logic                            control_out_two,
	output      logic                            timer_output,
	output      logic                            dacClock,
	output      logic                            serialOut,
	output      logic                            sample_hold_one,
	output      logic                            sample_hold_two,
	input  wire logic                            toneValid,
	output      logic                            toneReady,
	input  wire logic [fsh_pkg::SAMPLE_W-1:0]    toneLeft,
	input  wire logic [fsh_pkg::SAMPLE_W-1:0]    toneRight
);
	import fsh_pkg::*;

	if (TA_PRESCALE < 1 || TA_PRESCALE > 65536 || TB_PRESCALE < 1 || TB_PRESCALE > 65536)
		$error("fsh_host_port: prescale out of range");

	localparam int FRAME_W = 2 * SAMPLE_W;
	localparam logic [PRESCALE_W-1:0] TA_LAST = PRESCALE_W'(TA_PRESCALE - 1);
	localparam logic [PRESCALE_W-1:0] TB_LAST = PRESCALE_W'(TB_PRESCALE - 1);
	localparam logic [4:0] LEFT_LAST  = 5'(SAMPLE_W - 1);
	localparam logic [4:0] RIGHT_LAST = 5'(FRAME_W - 1);

	// ----------------------------------------------------------------
	// Host bus decode
	// ----------------------------------------------------------------
	logic       wrPrev;
	logic [7:0] addrLatch;
	logic [7:0] regFile [0:REG_N-1];
	logic [7:0] status;
	logic       clearAll;
	wire        wrActive  = !chipSelectN && !writeN;
	wire        rdActive  = !chipSelectN && !readN;
	wire        wrStart   = wrActive && !wrPrev;
	wire        addrWr    = wrStart && !addr_data_select;
	wire        dataWr    = wrStart && addr_data_select;
	wire        ctrlWr    = dataWr && (addrLatch == ADDR_TIMER_CTRL);
	wire        fallTick  = dacClock;
	assign      clearAll  = !initial_clear_n;

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			addrLatch <= REG_RESET;
		else if (clearAll)
			addrLatch <= REG_RESET;
		else if (addrWr)
			addrLatch <= busIn;
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			for (int i = 0; i < REG_N; i++)
				regFile[i] <= REG_RESET;
		else if (clearAll)
			for (int i = 0; i < REG_N; i++)
				regFile[i] <= REG_RESET;
		else if (dataWr)
			regFile[addrLatch] <= busIn;
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wrPrev <= 1'b0;
			irqOut <= 1'b0;
			busOe  <= 1'b0;
			busOut <= STAT_RESET;
		end
		else
		begin
			wrPrev <= wrActive;
			irqOut <= 1'b0;                                     // Open drain: only pulled low
			busOe  <= rdActive && !clearAll;
			busOut <= status;
		end
	end

	// ----------------------------------------------------------------
	// Operating clock
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			dacClock <= 1'b0;
		else
			dacClock <= !dacClock;
	end

	// ----------------------------------------------------------------
	// Timers
	// ----------------------------------------------------------------
	logic [PRESCALE_W-1:0] preA;
	logic [PRESCALE_W-1:0] preB;
	logic [TA_W-1:0]       cntA;
	logic [TB_W-1:0]       cntB;
	logic                  flagA;
	logic                  flagB;
	wire  [7:0]            tctl    = regFile[ADDR_TIMER_CTRL];
	wire  [TA_W-1:0]       loadA   = {regFile[ADDR_TIMER_A_HI], regFile[ADDR_TIMER_A_LO][1:0]};
	wire  [TB_W-1:0]       loadB   = regFile[ADDR_TIMER_B];
	wire                   tickA   = fallTick && tctl[TCTL_RUN_A] && (preA == TA_LAST);
	wire                   tickB   = fallTick && tctl[TCTL_RUN_B] && (preB == TB_LAST);
	wire                   ovfA    = tickA && (cntA == {TA_W{1'b1}});
	wire                   ovfB    = tickB && (cntB == {TB_W{1'b1}});
	wire                   setA    = ovfA && tctl[TCTL_IRQEN_A];
	wire                   setB    = ovfB && tctl[TCTL_IRQEN_B];
	wire                   clrA    = ctrlWr && busIn[TCTL_CLR_A];
	wire                   clrB    = ctrlWr && busIn[TCTL_CLR_B];
	wire                   stopA   = clearAll || !tctl[TCTL_RUN_A] || tickA;
	wire                   stopB   = clearAll || !tctl[TCTL_RUN_B] || tickB;
	wire  [PRESCALE_W-1:0] next_preA = stopA ? '0 : (fallTick ? preA + 1'b1 : preA);
	wire  [PRESCALE_W-1:0] next_preB = stopB ? '0 : (fallTick ? preB + 1'b1 : preB);
	assign                 status  = {6'h00, flagB, flagA};

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			preA <= '0;
			preB <= '0;
		end
		else
		begin
			preA <= next_preA;
			preB <= next_preB;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			cntA <= '0;
		else if (clearAll)
			cntA <= '0;
		else if (!tctl[TCTL_RUN_A] || ovfA)
			cntA <= loadA;
		else if (tickA)
			cntA <= cntA + 1'b1;
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			cntB <= '0;
		else if (clearAll)
			cntB <= '0;
		else if (!tctl[TCTL_RUN_B] || ovfB)
			cntB <= loadB;
		else if (tickB)
			cntB <= cntB + 1'b1;
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			flagA <= 1'b0;
			flagB <= 1'b0;
		end
		else if (clearAll)
		begin
			flagA <= 1'b0;
			flagB <= 1'b0;
		end
		else
		begin
			// Set wins over a clear in the same cycle
			flagA <= setA || (flagA && !clrA);
			flagB <= setB || (flagB && !clrB);
		end
	end

	// ----------------------------------------------------------------
	// Pin outputs, changed only as the converter clock falls or while initial_clear_n is low
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			irqOe           <= 1'b0;
			control_out_one <= 1'b0;
			control_out_two <= 1'b0;
			timer_output    <= 1'b0;
		end
		else if (clearAll)
		begin
			irqOe           <= 1'b0;
			control_out_one <= 1'b0;
			control_out_two <= 1'b0;
			timer_output    <= 1'b0;
		end
		else if (fallTick)
		begin
			irqOe           <= flagA || flagB;
			control_out_one <= regFile[ADDR_CTRL_OUT][CTRL_ONE_BIT];
			control_out_two <= regFile[ADDR_CTRL_OUT][CTRL_TWO_BIT];
			timer_output    <= ovfA;
		end
	end

	// ----------------------------------------------------------------
	// Two-entry tone buffer
	// ----------------------------------------------------------------
	logic [FRAME_W-1:0] bufMem [0:1];
	logic               bufWrPtr;
	logic               bufRdPtr;
	logic [1:0]         bufCount;
	logic               bufPop;
	wire                bufPush   = toneValid && toneReady;
	wire [1:0]          next_cnt  = bufCount + {1'b0, bufPush} - {1'b0, bufPop};

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			bufWrPtr  <= 1'b0;
			bufRdPtr  <= 1'b0;
			bufCount  <= 2'h0;
			toneReady <= 1'b0;
		end
		else if (clearAll)
		begin
			bufWrPtr  <= 1'b0;
			bufRdPtr  <= 1'b0;
			bufCount  <= 2'h0;
			toneReady <= 1'b0;
		end
		else
		begin
			bufWrPtr  <= bufWrPtr ^ bufPush;
			bufRdPtr  <= bufRdPtr ^ bufPop;
			bufCount  <= next_cnt;
			toneReady <= (next_cnt != 2'h2);
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (bufPush)
			bufMem[bufWrPtr] <= {toneLeft, toneRight};
	end

	// ----------------------------------------------------------------
	// Serializer
	// ----------------------------------------------------------------
	fsh_ser_state_t     serState;
	fsh_ser_state_t     next_serState;
	logic [FRAME_W-1:0] shiftReg;
	logic [4:0]         bitCnt;
	wire                frameEnd  = (serState == SER_IDLE) || (bitCnt == RIGHT_LAST);
	wire                bufHasWord = (bufCount != 2'h0);
	assign              bufPop    = fallTick && frameEnd && bufHasWord;

	always_comb
	begin
		next_serState = serState;
		case (serState)
			SER_IDLE:  next_serState = SER_LEFT;
			SER_LEFT:  next_serState = (bitCnt == LEFT_LAST) ? SER_RIGHT : SER_LEFT;
			SER_RIGHT: next_serState = (bitCnt == RIGHT_LAST) ? SER_LEFT : SER_RIGHT;
			default:   next_serState = SER_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			serState <= SER_IDLE;
			shiftReg <= '0;
			bitCnt   <= 5'h00;
		end
		else if (clearAll)
		begin
			serState <= SER_IDLE;
			shiftReg <= '0;
			bitCnt   <= 5'h00;
		end
		else if (fallTick)
		begin
			serState <= next_serState;
			bitCnt   <= frameEnd ? 5'h00 : bitCnt + 5'h01;
			// A starved buffer sends a silent frame
			if (frameEnd)
				shiftReg <= bufHasWord ? bufMem[bufRdPtr] : '0;
			else
				shiftReg <= {shiftReg[FRAME_W-2:0], 1'b0};
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			serialOut       <= 1'b0;
			sample_hold_one <= 1'b0;
			sample_hold_two <= 1'b0;
		end
		else if (clearAll)
		begin
			serialOut       <= 1'b0;
			sample_hold_one <= 1'b0;
			sample_hold_two <= 1'b0;
		end
		else if (fallTick)
		begin
			serialOut       <= (serState != SER_IDLE) && shiftReg[FRAME_W-1];
			sample_hold_one <= (serState == SER_LEFT) && (bitCnt == LEFT_LAST);
			sample_hold_two <= (serState == SER_RIGHT) && (bitCnt == RIGHT_LAST);
		end
	end

endmodule

// ### verilog/fsh_pkg.sv
package fsh_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int BUS_W    = 8;
	localparam int SAMPLE_W = 16;
	localparam int TA_W     = 10;
	localparam int TB_W     = 8;
	localparam int REG_N    = 256;

	// ----------------------------------------------------------------
	// Internal register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_TIMER_A_HI = 8'h10;
	localparam logic [7:0] ADDR_TIMER_A_LO = 8'h11;
	localparam logic [7:0] ADDR_TIMER_B    = 8'h12;
	localparam logic [7:0] ADDR_TIMER_CTRL = 8'h14;
	localparam logic [7:0] ADDR_CTRL_OUT   = 8'h1B;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int TCTL_RUN_A   = 0;
	localparam int TCTL_RUN_B   = 1;
	localparam int TCTL_IRQEN_A = 2;
	localparam int TCTL_IRQEN_B = 3;
	localparam int TCTL_CLR_A   = 4;
	localparam int TCTL_CLR_B   = 5;
	localparam int CTRL_ONE_BIT = 6;
	localparam int CTRL_TWO_BIT = 7;
	localparam int STAT_FLAG_A  = 0;
	localparam int STAT_FLAG_B  = 1;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_RESET  = 8'h00;
	localparam logic [7:0] STAT_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Timing counts, in operating clock periods
	// ----------------------------------------------------------------
	localparam int TA_PRESCALE = 64;
	localparam int TB_PRESCALE = 1024;
	localparam int PRESCALE_W  = 16;

	// ----------------------------------------------------------------
	// Serializer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0]
	{
		SER_IDLE  = 3'b001,
		SER_LEFT  = 3'b010,
		SER_RIGHT = 3'b100
	} fsh_ser_state_t;

endpackage

// ### tb/fsh_host_port_checker.sv
`timescale 1ns/1ps
module fsh_host_port_checker
(
	input wire logic				sys_clk,
	input wire logic				sys_rst,
	input wire logic				initial_clear_n,
	input wire logic				chipSelectN,
	input wire logic				readN,
	input wire logic [fsh_pkg::BUS_W-1:0]	busOut,
	input wire logic				busOe,
	input wire logic				irqOut,
	input wire logic				irqOe,
	input wire logic				control_out_one,
	input wire logic				control_out_two,
	input wire logic				timer_output,
	input wire logic				dacClock,
	input wire logic				serialOut,
	input wire logic				sample_hold_one,
	input wire logic				sample_hold_two,
	input wire logic				toneReady
);
	import fsh_pkg::*;

	// ------------------------------------------------------------
	// Port timing
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst || !initial_clear_n);

	property p_dac_rate;
		1'b1 |=> dacClock != $past(dacClock);
	endproperty
	a_dac_rate: assert property (p_dac_rate) else $error("dac clock stalled");

	property p_fall_only;
		$changed({irqOe, control_out_one, control_out_two, timer_output,
			sample_hold_one, sample_hold_two, serialOut}) |-> $past(dacClock);
	endproperty
	a_fall_only: assert property (p_fall_only) else $error("pin moved off a fall");

	property p_read_ans;
		!chipSelectN && !readN |=> busOe;
	endproperty
	a_read_ans: assert property (p_read_ans) else $error("read not answered");

	property p_bus_free;
		busOe |-> !$past(chipSelectN) && !$past(readN);
	endproperty
	a_bus_free: assert property (p_bus_free) else $error("bus driven unasked");

	property p_cs_gate;
		chipSelectN |=> !busOe;
	endproperty
	a_cs_gate: assert property (p_cs_gate) else $error("bus driven unselected");

	property p_status;
		busOe |-> busOut[7:2] == 6'h00;
	endproperty
	a_status: assert property (p_status) else $error("status spare bits set");

	property p_open_drain;
		irqOe |-> !irqOut;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("interrupt pin high");

	property p_sh_pair;
		$rose(sample_hold_one) |-> ##32 $rose(sample_hold_two);
	endproperty
	a_sh_pair: assert property (p_sh_pair) else $error("hold strobes misplaced");

	property p_sh_width;
		$rose(sample_hold_one) |=> sample_hold_one ##1 !sample_hold_one;
	endproperty
	a_sh_width: assert property (p_sh_width) else $error("hold strobe width");

	property p_clear;
		disable iff (sys_rst)
		!initial_clear_n [*3] |-> !control_out_one && !control_out_two && !busOe
			&& !toneReady && !irqOe && !sample_hold_one;
	endproperty
	a_clear: assert property (p_clear) else $error("clear left state");
endmodule

bind fsh_host_port fsh_host_port_checker u_chk
(
	.sys_clk, .sys_rst, .initial_clear_n, .chipSelectN, .readN, .busOut, .busOe,
	.irqOut, .irqOe, .control_out_one, .control_out_two, .timer_output, .dacClock,
	.serialOut, .sample_hold_one, .sample_hold_two, .toneReady
);

// ### tb/fsh_dac_model.sv
`timescale 1ns/1ps
module fsh_dac_model
(
	input wire logic				dacClock,
	input wire logic				serialOut,
	input wire logic				sample_hold_one,
	input wire logic				sample_hold_two,
	output logic [fsh_pkg::SAMPLE_W-1:0]	leftHeld,
	output logic [fsh_pkg::SAMPLE_W-1:0]	rightHeld,
	output int					frameCnt
);
	import fsh_pkg::*;

	logic [31:0]	shiftReg;
	logic [31:0]	next_shift;

	// ------------------------------------------------------------
	// Capture on the rising converter clock, between data changes
	// ------------------------------------------------------------
	assign next_shift = {shiftReg[30:0], serialOut};

	initial
	begin
		shiftReg = '0;
		leftHeld = '0;
		rightHeld = '0;
		frameCnt = 0;
	end

	always @(posedge dacClock)
	begin
		shiftReg <= next_shift;
		if (sample_hold_one)
			leftHeld <= next_shift[15:0];
		if (sample_hold_two)
		begin
			rightHeld <= next_shift[15:0];
			frameCnt <= frameCnt + 1;
		end
	end
endmodule

// ### tb/fsh_host_port_tb_top.sv
`timescale 1ns/1ps
module fsh_host_port_tb_top;
	import fsh_pkg::*;

	typedef struct packed {logic withAddr; logic [7:0] addr; logic [7:0] data; logic [1:0] ctl;}
		fsh_row_t;

	logic			sys_clk, sys_rst, initial_clear_n, chipSelectN, writeN, readN;
	logic			addr_data_select, busOe, irqOut, irqOe, control_out_one, control_out_two;
	logic			timer_output, dacClock, serialOut, sample_hold_one, sample_hold_two;
	logic			toneValid, toneReady, sawFull, sawTimer, irqN;
	logic [7:0]		hostBus, busOut, busIn, st;
	logic [15:0]		toneLeft, toneRight, leftHeld, rightHeld;
	int			frameCnt, seenCnt, f, n_fail, samples_checked;
	logic [15:0]		lw [3] = '{16'hA5C3, 16'h8001, 16'h1234};
	logic [15:0]		rw [3] = '{16'h3C5A, 16'h7FFE, 16'hFEDC};
	fsh_row_t		rows [5] = '{'{1'h1, ADDR_CTRL_OUT, 8'h40, 2'h1},
		'{1'h0, 8'h00, 8'h80, 2'h2}, '{1'h1, ADDR_CTRL_OUT, 8'hC0, 2'h3},
		'{1'h1, ADDR_TIMER_B, 8'h00, 2'h3}, '{1'h1, ADDR_CTRL_OUT, 8'h00, 2'h0}};

	assign busIn = busOe ? busOut : hostBus;
	assign irqN = irqOe ? irqOut : 1'h1;

	fsh_host_port #(.TA_PRESCALE(2), .TB_PRESCALE(4)) dut
	(
		.sys_clk, .sys_rst, .initial_clear_n, .chipSelectN, .writeN, .readN,
		.addr_data_select, .busIn, .busOut, .busOe, .irqOut, .irqOe, .control_out_one,
		.control_out_two, .timer_output, .dacClock, .serialOut, .sample_hold_one,
		.sample_hold_two, .toneValid, .toneReady, .toneLeft, .toneRight
	);

	fsh_dac_model dac
	(
		.dacClock, .serialOut, .sample_hold_one, .sample_hold_two, .leftHeld, .rightHeld,
		.frameCnt
	);

	// ------------------------------------------------------------
	// Clock from its own generator, watchers and helpers
	// ------------------------------------------------------------
	initial
	begin
		sys_clk = '0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk)
	begin
		if (toneValid && toneReady === 1'h0)
			sawFull <= '1;
		if (timer_output === 1'h1)
			sawTimer <= '1;
	end

	task automatic chk(input string what, input logic [15:0] expv, input logic [15:0] got);
		samples_checked++;
		if (got !== expv)
		begin
			$display("unexpected %s: expected %h, seen %h", what, expv, got);
			n_fail++;
		end
	endtask

	task automatic busWrite(input logic sel, input logic [7:0] d);
		@(posedge sys_clk);
		#1;
		chipSelectN = '0;
		writeN = '0;
		addr_data_select = sel;
		hostBus = d;
		@(posedge sys_clk);
		#1;
		chipSelectN = '1;
		writeN = '1;
	endtask

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		busWrite(1'h0, a);
		busWrite(1'h1, d);
	endtask

	task automatic busRead(output logic [7:0] d);
		@(posedge sys_clk);
		#1;
		chipSelectN = '0;
		readN = '0;
		@(posedge sys_clk);
		#1;
		d = busIn;
		chk("read enable", 16'h1, busOe);
		chipSelectN = '1;
		readN = '1;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic waitIrq();
		for (int i = 0; i < 400 && irqN !== 1'h0; i++)
			settle(1);
		chk("interrupt pin", 16'h0, irqN);
	endtask

	task automatic pushTone(input logic [15:0] l, input logic [15:0] r);
		toneValid = '1;
		toneLeft = l;
		toneRight = r;
		for (int i = 0; i < 300 && toneReady !== 1'h1; i++)
			settle(1);
		settle(1);
	endtask

	task automatic give_verdict();
		$display("checks %0d, failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		#100000;
		n_fail++;
		give_verdict();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		{sys_rst, initial_clear_n, chipSelectN, writeN, readN} = '1;
		{addr_data_select, toneValid, sawFull, sawTimer, hostBus, toneLeft, toneRight} = '0;
		n_fail = 0;
		samples_checked = 0;
		settle(20);
		sys_rst = '0;
		settle(2);
		chk("idle pins", 16'h1, {control_out_two, control_out_one, busOe, irqN});
		foreach (rows[k])
		begin
			if (rows[k].withAddr)
				busWrite(1'h0, rows[k].addr);
			busWrite(1'h1, rows[k].data);
			settle(4);
			chk("control outputs", rows[k].ctl, {control_out_two, control_out_one});
		end
		writeN = '0;
		addr_data_select = '1;
		hostBus = 8'hC0;
		settle(3);
		writeN = '1;
		readN = '0;
		settle(3);
		chk("unselected bus", 16'h0, busOe);
		readN = '1;
		settle(2);
		chk("unselected write", 16'h0, {control_out_two, control_out_one});
		wreg(ADDR_TIMER_A_HI, 8'hFF);
		wreg(ADDR_TIMER_A_LO, 8'h03);
		wreg(ADDR_TIMER_CTRL, 8'h05);
		waitIrq();
		chk("timer output", 16'h1, sawTimer);
		busRead(st);
		chk("status a", 16'h01, st);
		wreg(ADDR_TIMER_CTRL, 8'h00);
		busWrite(1'h1, 8'h10);
		settle(8);
		busRead(st);
		chk("status cleared", 16'h01, {st, irqN});
		wreg(ADDR_TIMER_B, 8'hFF);
		wreg(ADDR_TIMER_CTRL, 8'h0A);
		waitIrq();
		busRead(st);
		chk("status b", 16'h02, st);
		wreg(ADDR_TIMER_CTRL, 8'h02);
		busWrite(1'h1, 8'h22);
		settle(100);
		busRead(st);
		chk("status masked", 16'h01, {st, irqN});
		for (int i = 0; i < 100 && sample_hold_one !== 1'h1; i++)
			settle(1);
		seenCnt = frameCnt;
		for (int k = 0; k < 3; k++)
			pushTone(lw[k], rw[k]);
		toneValid = '0;
		chk("buffer refused", 16'h1, sawFull);
		f = 0;
		for (int i = 0; i < 4000 && f < 3; i++)
		begin
			settle(1);
			if (frameCnt != seenCnt)
			begin
				seenCnt = frameCnt;
				if (f > 0 || leftHeld !== 16'h0)
				begin
					chk("left word", lw[f], leftHeld);
					chk("right word", rw[f], rightHeld);
					f++;
				end
			end
		end
		chk("frames", 16'h3, f[15:0]);
		wreg(ADDR_CTRL_OUT, 8'hC0);
		settle(4);
		initial_clear_n = '0;
		settle(4);
		chk("cleared controls", 16'h0, {control_out_two, control_out_one});
		initial_clear_n = '1;
		busWrite(1'h1, 8'h40);
		settle(4);
		chk("address cleared", 16'h0, {control_out_two, control_out_one});
		busRead(st);
		chk("status after clear", 16'h00, st);
		give_verdict();
	end
endmodule
